// ### shared/lpcs_pkg.sv
// constants and types for the line port configuration and status bank
// assumes a byte-wide register port with one-cycle read latency
package lpcs_pkg;

    localparam int          LPCS_AW          = 8;
    localparam int          LPCS_DW          = 8;

    localparam logic [7:0]  LPCS_OFS_TRIG    = 8'h8f;
    localparam logic [7:0]  LPCS_OFS_CFGA    = 8'ha0;
    localparam logic [7:0]  LPCS_OFS_CFGB    = 8'ha1;
    localparam logic [7:0]  LPCS_OFS_STAT    = 8'ha2;
    localparam logic [7:0]  LPCS_OFS_IRQ_ST  = 8'ha3;
    localparam logic [7:0]  LPCS_OFS_IRQ_MSK = 8'ha4;

    localparam int          LPCS_TRIG_BIT    = 5;

    localparam int          LPCS_CA_PATTERN  = 7;
    localparam int          LPCS_CA_LLOOP    = 6;
    localparam int          LPCS_CA_RLOOP    = 5;
    localparam int          LPCS_CA_AUTO     = 4;
    localparam int          LPCS_CA_RATE_HI  = 3;
    localparam int          LPCS_CA_RATE_LO  = 2;
    localparam int          LPCS_CA_LOCKREF  = 1;
    localparam logic [7:0]  LPCS_CA_MASK     = 8'hfe;

    localparam int          LPCS_CB_TXTIME   = 4;
    localparam int          LPCS_CB_DEEMP_HI = 3;
    localparam int          LPCS_CB_DEEMP_LO = 2;
    localparam int          LPCS_CB_MODE_HI  = 1;
    localparam int          LPCS_CB_MODE_LO  = 0;
    localparam logic [7:0]  LPCS_CB_MASK     = 8'h1f;

    localparam int          LPCS_ST_CARRIER  = 7;
    localparam int          LPCS_ST_UNLOCK   = 5;
    localparam int          LPCS_ST_ABSENT   = 4;
    localparam int          LPCS_ST_RATE_HI  = 3;
    localparam int          LPCS_ST_RATE_LO  = 2;
    localparam int          LPCS_ST_PASS     = 1;
    localparam int          LPCS_ST_OVERRUN  = 0;

    // interrupt status bits
    localparam int          LPCS_IRQ_W       = 4;
    localparam int          LPCS_EV_ABSENT   = 0;
    localparam int          LPCS_EV_UNLOCK   = 1;
    localparam int          LPCS_EV_OVERRUN  = 2;
    localparam int          LPCS_EV_PASS     = 3;

    localparam logic [7:0]  LPCS_RST_CFGA    = 8'h00;
    localparam logic [7:0]  LPCS_RST_CFGB    = 8'h00;

    typedef enum logic [1:0] {
        LPCS_RATE_OC48,
        LPCS_RATE_GBE,
        LPCS_RATE_OC12,
        LPCS_RATE_OC3
    } lpcs_rate_t;

    typedef enum logic [1:0] {
        LPCS_MODE_DUPLEX,
        LPCS_MODE_TX_ONLY,
        LPCS_MODE_RX_ONLY,
        LPCS_MODE_REPEATER
    } lpcs_mode_t;

endpackage

// ### verilog/lpcs_sync.sv
// two-flop synchroniser for a bus of asynchronous levels
// assumes inputs are quasi-static levels from outside the clock domain
`timescale 1ns/10ps
`default_nettype none
module lpcs_sync #(
    parameter int W = 1
) (
    input  wire logic         sys_clk_in,
    input  wire logic         rst_in,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);

    if (W < 1) begin : g_bad_width
        $error("lpcs_sync: width must be at least one");
    end

    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] sync;
    } lpcs_sync_state_t;

    lpcs_sync_state_t state_r;
    lpcs_sync_state_t state_nxt;

    always_comb begin
        state_nxt      = state_r;
        state_nxt.meta = async_in;
        state_nxt.sync = state_r.meta;
    end

    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            state_r <= '0;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign sync_out = state_r.sync;

endmodule
`default_nettype wire

// ### verilog/lpcs_top.sv
// line port configuration and status register bank
// assumes a byte register port from the same clock; transceiver and optical
// module status pins are asynchronous levels
`timescale 1ns/10ps
`default_nettype none
module lpcs_top
    import lpcs_pkg::*;
(
    input  wire logic               sys_clk_in,
    input  wire logic               rst_in,
    // register port
    input  wire logic [LPCS_AW-1:0] reg_addr_in,
    input  wire logic [LPCS_DW-1:0] reg_wdata_in,
    input  wire logic               reg_wr_in,
    input  wire logic               reg_rd_in,
    output logic      [LPCS_DW-1:0] reg_rdata_out,
    // synchronized start for ports 1 and 2
    output logic                    sync_start_out,
    // transceiver controls
    output logic                    pattern_test_enable_out,
    output logic                    local_loop_out,
    output logic                    remote_loop_out,
    output logic                    rate_auto_sense_out,
    output logic      [1:0]         expected_rx_rate_out,
    output logic                    rx_lock_to_tx_out,
    output logic                    tx_timing_from_rx_out,
    output logic      [1:0]         deemphasis_level_out,
    output logic      [1:0]         transceiver_mode_out,
    // status pins
    input  wire logic               carrier_present_in,
    input  wire logic               pll_unlocked_in,
    input  wire logic               signal_lost_in,
    input  wire logic               frame_detected_in,
    input  wire logic [1:0]         sensed_rx_rate_in,
    input  wire logic               pattern_check_pass_in,
    input  wire logic               tx_fifo_overrun_in,
    // interrupt
    output logic                    irq_out
);

    //------------------------------------------------------------------
    // status input synchronisation
    //------------------------------------------------------------------

    localparam int SYNC_W = 8;

    logic [SYNC_W-1:0] pins_async;
    logic [SYNC_W-1:0] pins_sync;

    assign pins_async = {carrier_present_in,
                         pll_unlocked_in,
                         signal_lost_in,
                         frame_detected_in,
                         sensed_rx_rate_in,
                         pattern_check_pass_in,
                         tx_fifo_overrun_in};

    lpcs_sync #(
        .W (SYNC_W)
    ) i_lpcs_sync (
        .sys_clk_in (sys_clk_in),
        .rst_in     (rst_in),
        .async_in   (pins_async),
        .sync_out   (pins_sync)
    );

    logic       s_carrier;
    logic       s_unlock;
    logic       s_lost;
    logic       s_frame;
    logic [1:0] s_rate;
    logic       s_pass;
    logic       s_overrun;

    assign s_carrier = pins_sync[7];
    assign s_unlock  = pins_sync[6];
    assign s_lost    = pins_sync[5];
    assign s_frame   = pins_sync[4];
    assign s_rate    = pins_sync[3:2];
    assign s_pass    = pins_sync[1];
    assign s_overrun = pins_sync[0];

    //------------------------------------------------------------------
    // state
    //------------------------------------------------------------------

    typedef struct packed {
        logic [7:0]            cfg_a;
        logic [7:0]            cfg_b;
        logic                  absent;
        logic                  sync_start;
        logic                  unlock_d;
        logic                  overrun_d;
        logic                  pass_d;
        logic                  absent_d;
        logic [LPCS_IRQ_W-1:0] irq_st;
        logic [LPCS_IRQ_W-1:0] irq_msk;
        logic [LPCS_DW-1:0]    rdata;
    } lpcs_state_t;

    lpcs_state_t state_r;
    lpcs_state_t state_nxt;

    logic [7:0]            status_view;
    logic [LPCS_IRQ_W-1:0] events;
    logic                  wr_trig;
    logic                  wr_cfga;
    logic                  wr_cfgb;
    logic                  wr_irq_st;
    logic                  wr_irq_msk;

    assign wr_trig    = reg_wr_in && (reg_addr_in == LPCS_OFS_TRIG);
    assign wr_cfga    = reg_wr_in && (reg_addr_in == LPCS_OFS_CFGA);
    assign wr_cfgb    = reg_wr_in && (reg_addr_in == LPCS_OFS_CFGB);
    assign wr_irq_st  = reg_wr_in && (reg_addr_in == LPCS_OFS_IRQ_ST);
    assign wr_irq_msk = reg_wr_in && (reg_addr_in == LPCS_OFS_IRQ_MSK);

    //------------------------------------------------------------------
    // status register view
    //------------------------------------------------------------------

    always_comb begin
        status_view                  = 8'h00;
        status_view[LPCS_ST_CARRIER] = s_carrier;
        status_view[LPCS_ST_UNLOCK]  = s_unlock;
        status_view[LPCS_ST_ABSENT]  = state_r.absent;
        status_view[LPCS_ST_RATE_HI:LPCS_ST_RATE_LO] = s_rate;
        // pass flag only meaningful in pattern mode
        status_view[LPCS_ST_PASS]    = s_pass && state_r.cfg_a[LPCS_CA_PATTERN];
        status_view[LPCS_ST_OVERRUN] = s_overrun;
    end

    //------------------------------------------------------------------
    // rising-edge events
    //------------------------------------------------------------------

    always_comb begin
        events                  = '0;
        // registered flag edge, keeps the event path free of next-state loops
        events[LPCS_EV_ABSENT]  = state_r.absent && !state_r.absent_d;
        events[LPCS_EV_UNLOCK]  = s_unlock && !state_r.unlock_d;
        events[LPCS_EV_OVERRUN] = s_overrun && !state_r.overrun_d;
        events[LPCS_EV_PASS]    = status_view[LPCS_ST_PASS] && !state_r.pass_d;
    end

    //------------------------------------------------------------------
    // next state
    //------------------------------------------------------------------

    always_comb begin
        state_nxt = state_r;

        // trigger bit is write-only, a one-cycle start pulse
        state_nxt.sync_start = wr_trig && reg_wdata_in[LPCS_TRIG_BIT];

        if (wr_cfga) begin
            state_nxt.cfg_a = reg_wdata_in & LPCS_CA_MASK;
        end
        if (wr_cfgb) begin
            state_nxt.cfg_b = reg_wdata_in & LPCS_CB_MASK;
        end

        // loss of signal holds until a frame is seen; loss wins
        if (s_lost) begin
            state_nxt.absent = 1'b1;
        end else if (s_frame) begin
            state_nxt.absent = 1'b0;
        end

        state_nxt.absent_d  = state_r.absent;
        state_nxt.unlock_d  = s_unlock;
        state_nxt.overrun_d = s_overrun;
        state_nxt.pass_d    = status_view[LPCS_ST_PASS];

        // write-one-to-clear, a new event wins
        if (wr_irq_st) begin
            state_nxt.irq_st = state_r.irq_st & ~reg_wdata_in[LPCS_IRQ_W-1:0];
        end
        state_nxt.irq_st = state_nxt.irq_st | events;

        if (wr_irq_msk) begin
            state_nxt.irq_msk = reg_wdata_in[LPCS_IRQ_W-1:0];
        end

        state_nxt.rdata = '0;
        if (reg_rd_in) begin
            unique case (reg_addr_in)
                LPCS_OFS_TRIG: begin
                    state_nxt.rdata = 8'h00;
                end
                LPCS_OFS_CFGA: begin
                    state_nxt.rdata = state_r.cfg_a;
                end
                LPCS_OFS_CFGB: begin
                    state_nxt.rdata = state_r.cfg_b;
                end
                LPCS_OFS_STAT: begin
                    state_nxt.rdata = status_view;
                end
                LPCS_OFS_IRQ_ST: begin
                    state_nxt.rdata = {{(LPCS_DW-LPCS_IRQ_W){1'b0}}, state_r.irq_st};
                end
                LPCS_OFS_IRQ_MSK: begin
                    state_nxt.rdata = {{(LPCS_DW-LPCS_IRQ_W){1'b0}}, state_r.irq_msk};
                end
                default: begin
                    state_nxt.rdata = 8'h00;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            state_r       <= '0;
            state_r.cfg_a <= LPCS_RST_CFGA;
            state_r.cfg_b <= LPCS_RST_CFGB;
        end else begin
            state_r <= state_nxt;
        end
    end

    //------------------------------------------------------------------
    // outputs
    //------------------------------------------------------------------

    assign reg_rdata_out           = state_r.rdata;
    assign sync_start_out          = state_r.sync_start;
    assign pattern_test_enable_out = state_r.cfg_a[LPCS_CA_PATTERN];
    assign local_loop_out          = state_r.cfg_a[LPCS_CA_LLOOP];
    assign remote_loop_out         = state_r.cfg_a[LPCS_CA_RLOOP];
    // auto sensing only when the expected rate field is zero
    assign rate_auto_sense_out     = state_r.cfg_a[LPCS_CA_AUTO]
        && (state_r.cfg_a[LPCS_CA_RATE_HI:LPCS_CA_RATE_LO] == LPCS_RATE_OC48);
    assign expected_rx_rate_out    = state_r.cfg_a[LPCS_CA_RATE_HI:LPCS_CA_RATE_LO];
    assign rx_lock_to_tx_out       = state_r.cfg_a[LPCS_CA_LOCKREF];
    assign tx_timing_from_rx_out   = state_r.cfg_b[LPCS_CB_TXTIME];
    assign deemphasis_level_out    = state_r.cfg_b[LPCS_CB_DEEMP_HI:LPCS_CB_DEEMP_LO];
    assign transceiver_mode_out    = state_r.cfg_b[LPCS_CB_MODE_HI:LPCS_CB_MODE_LO];
    assign irq_out                 = |(state_r.irq_st & state_r.irq_msk);

endmodule
`default_nettype wire

// ### dv/lpcs_top_properties.sv
// timing checks on the line port config and status bank ports
// assumes the bind below and a single clock domain
`timescale 1ns/10ps
`default_nettype none
module lpcs_chk
    import lpcs_pkg::*;
(
    input wire logic               sys_clk_in,
    input wire logic               rst_in,
    input wire logic [LPCS_AW-1:0] reg_addr_in,
    input wire logic [LPCS_DW-1:0] reg_wdata_in,
    input wire logic               reg_wr_in,
    input wire logic               reg_rd_in,
    input wire logic [LPCS_DW-1:0] reg_rdata_out,
    input wire logic               sync_start_out,
    input wire logic               pattern_test_enable_out,
    input wire logic               local_loop_out,
    input wire logic               remote_loop_out,
    input wire logic               rate_auto_sense_out,
    input wire logic [1:0]         expected_rx_rate_out,
    input wire logic               rx_lock_to_tx_out,
    input wire logic               tx_timing_from_rx_out,
    input wire logic [1:0]         deemphasis_level_out,
    input wire logic [1:0]         transceiver_mode_out,
    input wire logic               carrier_present_in,
    input wire logic               pll_unlocked_in,
    input wire logic               signal_lost_in,
    input wire logic               frame_detected_in,
    input wire logic [1:0]         sensed_rx_rate_in,
    input wire logic               tx_fifo_overrun_in
);
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (rst_in);

    sequence s_wr(a);
        reg_wr_in && reg_addr_in == a;
    endsequence
    sequence s_rd(a);
        reg_rd_in && reg_addr_in == a;
    endsequence
    // status levels quiet long enough to cross the synchroniser
    sequence s_lines_settled;
        $stable({carrier_present_in, pll_unlocked_in, sensed_rx_rate_in, tx_fifo_overrun_in})[*3];
    endsequence
    sequence s_lost_held;
        signal_lost_in[*4];
    endsequence
    sequence s_found_held;
        (frame_detected_in && !signal_lost_in)[*4];
    endsequence

    chk_trig_pulse: assert property (s_wr(LPCS_OFS_TRIG) ##0 reg_wdata_in[5] |=> sync_start_out)
        else $error("trigger write gave no start pulse");
    chk_trig_quiet: assert property (!(reg_wr_in && reg_addr_in == LPCS_OFS_TRIG && reg_wdata_in[5])
        |=> !sync_start_out)
        else $error("start pulse without trigger write");
    chk_cfga_ctrl: assert property (s_wr(LPCS_OFS_CFGA) |=> {pattern_test_enable_out, local_loop_out,
        remote_loop_out, rx_lock_to_tx_out} == {$past(reg_wdata_in[7:5]), $past(reg_wdata_in[1])})
        else $error("config a controls differ from written value");
    chk_rate_sel: assert property (s_wr(LPCS_OFS_CFGA) |=> expected_rx_rate_out == $past(reg_wdata_in[3:2])
        && rate_auto_sense_out == ($past(reg_wdata_in[4]) && $past(reg_wdata_in[3:2]) == 2'b00))
        else $error("rate select or auto sense wrong");
    chk_cfgb_ctrl: assert property (s_wr(LPCS_OFS_CFGB) |=> {tx_timing_from_rx_out, deemphasis_level_out,
        transceiver_mode_out} == $past(reg_wdata_in[4:0]))
        else $error("config b controls differ from written value");
    chk_cfg_hold: assert property (!reg_wr_in |=> $stable({pattern_test_enable_out, local_loop_out,
        remote_loop_out, expected_rx_rate_out, tx_timing_from_rx_out, transceiver_mode_out}))
        else $error("control output moved without a write");
    chk_status_lines: assert property (s_lines_settled ##0 s_rd(LPCS_OFS_STAT) |=>
        {reg_rdata_out[7:5], reg_rdata_out[3:2], reg_rdata_out[0]} == {$past(carrier_present_in),
        1'b0, $past(pll_unlocked_in), $past(sensed_rx_rate_in), $past(tx_fifo_overrun_in)})
        else $error("status read does not follow settled lines");
    chk_pass_gate: assert property (s_rd(LPCS_OFS_STAT) ##0 !pattern_test_enable_out
        |=> !reg_rdata_out[1])
        else $error("pattern pass shown while pattern mode off");
    chk_absent_set: assert property (s_lost_held ##0 s_rd(LPCS_OFS_STAT) |=> reg_rdata_out[4])
        else $error("signal loss not shown");
    chk_absent_clear: assert property (s_found_held ##0 s_rd(LPCS_OFS_STAT) |=> !reg_rdata_out[4])
        else $error("signal absent flag not cleared by frame");
    chk_rd_idle: assert property (!reg_rd_in |=> reg_rdata_out == 8'h00)
        else $error("read data outside read answer cycle");
endmodule

bind lpcs_top lpcs_chk i_lpcs_chk (.*);
`default_nettype wire

// ### dv/lpcs_xcvr_model.sv
// behavioural line transceiver and optical module on the status pins
// assumes the bench commands the raw line events
`timescale 1ns/10ps
`default_nettype none
module lpcs_xcvr_model (
    input  wire logic       pattern_test_enable_out,
    input  wire logic       local_loop_out,
    input  wire logic       rate_auto_sense_out,
    input  wire logic [1:0] expected_rx_rate_out,
    input  wire logic       tx_timing_from_rx_out,
    input  wire logic       carrier_cmd_in,
    input  wire logic       unlock_cmd_in,
    input  wire logic       lost_cmd_in,
    input  wire logic       frame_cmd_in,
    input  wire logic [1:0] rate_cmd_in,
    input  wire logic       pass_cmd_in,
    input  wire logic       overrun_cmd_in,
    output logic            carrier_present_in,
    output logic            pll_unlocked_in,
    output logic            signal_lost_in,
    output logic            frame_detected_in,
    output logic [1:0]      sensed_rx_rate_in,
    output logic            pattern_check_pass_in,
    output logic            tx_fifo_overrun_in
);
    assign carrier_present_in    = carrier_cmd_in;
    assign pll_unlocked_in       = unlock_cmd_in;
    assign signal_lost_in        = lost_cmd_in;
    assign frame_detected_in     = frame_cmd_in;
    // rate sensed only when asked to, else the expected rate
    assign sensed_rx_rate_in     = rate_auto_sense_out ? rate_cmd_in : expected_rx_rate_out;
    // own pattern returns through local loop
    assign pattern_check_pass_in = pass_cmd_in | (pattern_test_enable_out & local_loop_out);
    // spill only possible with loop timing
    assign tx_fifo_overrun_in    = overrun_cmd_in & tx_timing_from_rx_out;
endmodule
`default_nettype wire

// ### dv/tb_lpcs_top.sv
// bench for the line port config and status bank
// assumes the transceiver model and the bound checker
`timescale 1ns/10ps
`default_nettype none
module tb_lpcs_top
    import lpcs_pkg::*;
;
    logic       sys_clk_in, rst_in, reg_wr_in, reg_rd_in, sync_start_out, irq_out;
    logic [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out, rd_val, ca, cb;
    logic       pattern_test_enable_out, local_loop_out, remote_loop_out, rate_auto_sense_out;
    logic [1:0] expected_rx_rate_out, deemphasis_level_out, transceiver_mode_out, sensed_rx_rate_in;
    logic       rx_lock_to_tx_out, tx_timing_from_rx_out, carrier_present_in, pll_unlocked_in;
    logic       signal_lost_in, frame_detected_in, pattern_check_pass_in, tx_fifo_overrun_in;
    logic       carrier_cmd_in, unlock_cmd_in, lost_cmd_in, frame_cmd_in, pass_cmd_in;
    logic       overrun_cmd_in, pulse_seen, absent_exp;
    logic [1:0] rate_cmd_in;
    int         n_mismatch = 0;
    int         cmp_count  = 0;

    lpcs_top         i_lpcs_top (.*);
    lpcs_xcvr_model  i_lpcs_xcvr_model (.*);

    initial begin
        sys_clk_in = 1'b0;
        forever #12.5 sys_clk_in = ~sys_clk_in;
    end

    // ----------------------------------------
    // access tasks
    // ----------------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
        reg_wr_in    <= wr;
        reg_rd_in    <= !wr;
        reg_addr_in  <= a;
        reg_wdata_in <= d;
        @(posedge sys_clk_in);
        reg_wr_in <= 1'b0;
        reg_rd_in <= 1'b0;
        #1;
        rd_val     = reg_rdata_out;
        pulse_seen = sync_start_out;
        @(posedge sys_clk_in);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        bus(1'b0, a, 8'h00);
        chk(rd_val, exp);
    endtask
    task automatic set_ca(input logic [7:0] d);
        ca = d;
        wr(LPCS_OFS_CFGA, d);
    endtask
    task automatic set_cb(input logic [7:0] d);
        cb = d;
        wr(LPCS_OFS_CFGB, d);
    endtask
    task automatic settle();
        repeat (4) @(posedge sys_clk_in);
    endtask
    function automatic logic [7:0] stat_exp();
        logic [1:0] rate;
        rate = (ca[4] && ca[3:2] == 2'b00) ? rate_cmd_in : ca[3:2];
        return {carrier_cmd_in, 1'b0, unlock_cmd_in, absent_exp, rate,
                ca[7] & (pass_cmd_in | ca[6]), overrun_cmd_in & cb[4]};
    endfunction
    task automatic status_chk();
        settle();
        rd_chk(LPCS_OFS_STAT, stat_exp());
    endtask
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial begin
        rst_in = 1'b1;
        {reg_wr_in, reg_rd_in, reg_addr_in, reg_wdata_in} = '0;
        {carrier_cmd_in, unlock_cmd_in, lost_cmd_in, frame_cmd_in, pass_cmd_in} = '0;
        overrun_cmd_in = 1'b0;
        rate_cmd_in = 2'b10;
        {ca, cb, absent_exp} = '0;
        repeat (3) @(posedge sys_clk_in);
        rst_in <= 1'b0;
        @(posedge sys_clk_in);
        rd_chk(LPCS_OFS_CFGA, LPCS_RST_CFGA);
        rd_chk(LPCS_OFS_CFGB, LPCS_RST_CFGB);
        status_chk();
        chk({7'h00, irq_out}, 8'h00);
        $display("test reset done");
        for (int r = 0; r < 4; r++) begin
            set_ca({4'b1011, r[1:0], 2'b11});
            chk({pattern_test_enable_out, local_loop_out, remote_loop_out, rate_auto_sense_out,
                 expected_rx_rate_out, rx_lock_to_tx_out, 1'b0}, {ca[7:5], r == 0, ca[3:1], 1'b0});
            rd_chk(LPCS_OFS_CFGA, ca & LPCS_CA_MASK);
            status_chk();
        end
        $display("test config a done");
        for (int m = 0; m < 4; m++) begin
            set_cb({3'b111, m[0], 2'b00, m[1:0]});
            chk({3'b000, tx_timing_from_rx_out, deemphasis_level_out, transceiver_mode_out},
                cb & LPCS_CB_MASK);
            rd_chk(LPCS_OFS_CFGB, cb & LPCS_CB_MASK);
        end
        {carrier_cmd_in, unlock_cmd_in, overrun_cmd_in} <= 3'b111;
        status_chk();
        set_cb(8'h00);
        status_chk();
        $display("test config b done");
        wr(LPCS_OFS_TRIG, 8'h20);
        chk({7'h00, pulse_seen}, 8'h01);
        wr(LPCS_OFS_TRIG, 8'hdf);
        chk({7'h00, pulse_seen}, 8'h00);
        rd_chk(LPCS_OFS_TRIG, 8'h00);
        rd_chk(8'h55, 8'h00);
        wr(8'ha5, 8'hff);
        rd_chk(LPCS_OFS_CFGA, ca & LPCS_CA_MASK);
        $display("test trigger and map done");
        {lost_cmd_in, frame_cmd_in} <= 2'b11;
        absent_exp = 1'b1;
        status_chk();
        {lost_cmd_in, frame_cmd_in} <= 2'b00;
        status_chk();
        frame_cmd_in <= 1'b1;
        absent_exp = 1'b0;
        status_chk();
        frame_cmd_in <= 1'b0;
        $display("test signal absent done");
        pass_cmd_in <= 1'b1;
        status_chk();
        set_ca(8'h0c);
        status_chk();
        pass_cmd_in <= 1'b0;
        set_ca(8'hcc);
        status_chk();
        $display("test pattern done");
        unlock_cmd_in <= 1'b0;
        settle();
        wr(LPCS_OFS_IRQ_ST, 8'h0f);
        wr(LPCS_OFS_IRQ_MSK, 8'h00);
        unlock_cmd_in <= 1'b1;
        settle();
        rd_chk(LPCS_OFS_IRQ_ST, 8'h02);
        chk({7'h00, irq_out}, 8'h00);
        wr(LPCS_OFS_IRQ_MSK, 8'h02);
        chk({7'h00, irq_out}, 8'h01);
        rd_chk(LPCS_OFS_IRQ_MSK, 8'h02);
        wr(LPCS_OFS_IRQ_ST, 8'h02);
        chk({7'h00, irq_out}, 8'h00);
        rd_chk(LPCS_OFS_IRQ_ST, 8'h00);
        $display("test interrupt done");
        give_verdict();
    end

    // run cut short if the sequence hangs
    initial begin
        repeat (3000) @(posedge sys_clk_in);
        n_mismatch++;
        give_verdict();
    end
endmodule
`default_nettype wire
